// file: dv/tb_top.sv
`timescale 1ns/1ps
`include "usc_defs.svh"

module tb_top;
	import usc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic        ack;
	logic        rx_pin;
	logic [7:0]  rx_char;
	logic        rx_valid;
	logic        rx_owned;
	logic        match;
	logic        tx_pin;
	logic        tx_owned;
	logic        irq;
	logic [31:0] q;
	int          n_errors;
	int          num_checks;
	int          cycles;
	int          base;

	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;

	usc_status_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .rx_pin_i(rx_pin), .rx_char_i(rx_char),
		.rx_char_valid_i(rx_valid), .rx_pin_owned_o(rx_owned), .addr_match_o(match), .tx_pin_o(tx_pin),
		.tx_pin_owned_o(tx_owned), .irq_o(irq));

	usc_remote_model u_far (.clk_i(clk_i), .tx_i(tx_pin), .tx_owned_i(tx_owned), .rx_pin_o(rx_pin),
		.rx_char_o(rx_char), .rx_valid_o(rx_valid));

	task automatic give_verdict();
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask

	// Classic cycle: hold until ack sampled high, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		dat_w <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		wb(1'b0, a, 32'h0);
		check(n, q & m, e);
	endtask

	// Match is looked at in the strobe cycle itself
	task automatic probe(input logic [7:0] c, input logic e);
		fork
			u_far.send_char(c);
			begin
				@(posedge clk_i);
				@(posedge clk_i);
				check("addr_match", {31'h0, match}, {31'h0, e});
			end
		join
	endtask

	task automatic wait_frames(input int n);
		for (int k = 0; k < 1000 && u_far.n_frames < n; k++)
			@(posedge clk_i);
	endtask

	initial
	begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		dat_w = 32'h0;
		n_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`USC_ADDR_STA, 32'hFFFFFFFF, 32'h00000110, "sta_reset");
		rd(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
		wb(1'b1, `USC_ADDR_STA, 32'hFFA50000);
		rd(`USC_ADDR_STA, 32'hFFFFFFFF, 32'h01A50110, "sta_upper");
		// Address detection and receive pin hand-over
		wb(1'b1, `USC_ADDR_MODE, 32'h00008000);
		wb(1'b1, `USC_ADDR_STA, 32'h01A51000);
		check("rx_owned", {31'h0, rx_owned}, 32'h1);
		probe(8'hA5, 1'b1);
		probe(8'h5A, 1'b0);
		wb(1'b1, `USC_ADDR_STA, 32'h00A51000);
		probe(8'hA5, 1'b0);
		wb(1'b1, `USC_ADDR_STA, 32'h01A50000);
		check("rx_released", {31'h0, rx_owned}, 32'h0);
		probe(8'hA5, 1'b0);
		// Idle level for both polarities, plain then infrared
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b1, `USC_ADDR_MODE, i[1] ? 32'h00009000 : 32'h00008000);
			wb(1'b1, `USC_ADDR_STA, (i == 1 || i == 2) ? 32'h00002400 : 32'h00000400);
			repeat (2) @(posedge clk_i);
			check("tx_idle", {31'h0, tx_pin}, {31'h0, ~i[0]});
		end
		check("tx_owned", {31'h0, tx_owned}, 32'h1);
		wb(1'b1, `USC_ADDR_MODE, 32'h00008000);
		// Fill the buffer behind a busy shifter
		wb(1'b1, `USC_ADDR_IRQ_MASK, 32'h1);
		for (int i = 0; i < 5; i++)
			wb(1'b1, `USC_ADDR_TXDATA, 32'h31 + i);
		rd(`USC_ADDR_STA, 32'h00000200, 32'h00000200, "full");
		for (int s = 0; s < 3; s++)
		begin
			wb(1'b1, `USC_ADDR_STA, 32'h00000400 | (s << 14));
			wb(1'b1, `USC_ADDR_IRQ_STAT, 32'h1);
			@(posedge clk_i);
			check("irq_while_full", {31'h0, irq}, 32'h0);
		end
		// Abort flushes; empty code fires once the transmitter is back on
		wb(1'b1, `USC_ADDR_STA, 32'h00008000);
		rd(`USC_ADDR_STA, 32'h00000600, 32'h0, "flushed");
		check("tx_released", {31'h0, tx_owned}, 32'h0);
		wb(1'b1, `USC_ADDR_STA, 32'h00008400);
		@(posedge clk_i);
		check("irq_empty", {31'h0, irq}, 32'h1);
		repeat (200) @(posedge clk_i);
		// One whole character, done interrupt after stop bit
		base = u_far.n_frames;
		wb(1'b1, `USC_ADDR_STA, 32'h00004400);
		wb(1'b1, `USC_ADDR_TXDATA, 32'h3C);
		wb(1'b1, `USC_ADDR_IRQ_STAT, 32'h1);
		@(posedge clk_i);
		check("irq_busy", {31'h0, irq}, 32'h0);
		wait_frames(base + 1);
		check("char", {24'h0, u_far.last_char}, 32'h3C);
		check("stop", {31'h0, u_far.stop_ok}, 32'h1);
		repeat (20) @(posedge clk_i);
		check("irq_done", {31'h0, irq}, 32'h1);
		wb(1'b1, `USC_ADDR_STA, 32'h00000400);
		wb(1'b1, `USC_ADDR_IRQ_STAT, 32'h1);
		@(posedge clk_i);
		check("irq_space", {31'h0, irq}, 32'h1);
		// Break requested ahead of queued data
		wb(1'b1, `USC_ADDR_IRQ_MASK, 32'h2);
		wb(1'b1, `USC_ADDR_IRQ_STAT, 32'h3);
		base = u_far.n_frames;
		wb(1'b1, `USC_ADDR_STA, 32'h00000C00);
		wb(1'b1, `USC_ADDR_TXDATA, 32'h55);
		rd(`USC_ADDR_STA, 32'h00000800, 32'h00000800, "brk_pending");
		wait_frames(base + 2);
		check("brk_zeros", 32'(u_far.brk_zeros), 32'h1 + `USC_BRK_ZEROS);
		check("after_brk", {24'h0, u_far.last_char}, 32'h55);
		rd(`USC_ADDR_STA, 32'h00000800, 32'h0, "brk_cleared");
		rd(`USC_ADDR_IRQ_STAT, 32'h2, 32'h2, "brk_done");
		check("irq_brk", {31'h0, irq}, 32'h1);
		give_verdict();
	end
endmodule // tb_top

// file: dv/usc_remote_model.sv
`timescale 1ns/1ps

// Far-end transceiver: decodes tx frames, feeds received characters
module usc_remote_model
(
	input  wire logic  clk_i,
	input  wire logic  tx_i,
	input  wire logic  tx_owned_i,
	output logic       rx_pin_o,
	output logic [7:0] rx_char_o,
	output logic       rx_valid_o
);
	localparam int BIT = 16;
	int         n_frames;
	int         brk_zeros;
	int         zeros;
	logic [7:0] last_char;
	logic [7:0] sh;
	logic       stop_ok;
	logic       prev;

	// Line idles high, driven high by the model from time zero
	initial
	begin
		n_frames = 0;
		brk_zeros = 0;
		rx_pin_o = 1'b1;
		rx_char_o = 8'h00;
		rx_valid_o = 1'b0;
	end

	// Previous line level for start detection
	always @(posedge clk_i)
		prev <= tx_i;

	// Samples at bit centres; a zero run past the data counts a break
	always
	begin
		@(posedge clk_i);
		if (tx_owned_i && prev && !tx_i)
		begin
			repeat (BIT / 2) @(posedge clk_i);
			zeros = 1;
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk_i);
				sh = {tx_i, sh[7:1]};
				zeros = tx_i ? 0 : zeros + 1;
			end
			repeat (BIT) @(posedge clk_i);
			// Bounded so a stuck-low line cannot hang the decoder
			while (!tx_i && zeros < 20)
			begin
				zeros++;
				repeat (BIT) @(posedge clk_i);
			end
			stop_ok = tx_i;
			last_char = sh;
			if (sh == 8'h00)
				brk_zeros = zeros;
			n_frames++;
		end
	end

	// One-cycle character strobe; data scrambled outside it
	task automatic send_char(input logic [7:0] c);
		@(posedge clk_i);
		rx_char_o <= c;
		rx_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_char_o <= ~c;
		rx_valid_o <= 1'b0;
	endtask
endmodule // usc_remote_model

// file: rtl/usc_addr_match.sv
`timescale 1ns/1ps

module usc_addr_match
	import usc_pkg::*;
(
	input  wire logic       enable_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] char_i,
	input  wire logic       char_valid_i,
	output logic            match_o
);
	// Compare only while detection is on
	assign match_o = enable_i && char_valid_i && (char_i == addr_i);
endmodule // usc_addr_match

// file: rtl/usc_defs.svh
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

// Register byte addresses
`define USC_ADDR_STA       8'h00
`define USC_ADDR_MODE      8'h04
`define USC_ADDR_TXDATA    8'h08
`define USC_ADDR_IRQ_STAT  8'h0C
`define USC_ADDR_IRQ_MASK  8'h10

// Status/control field positions
`define USC_BIT_ADDR_DET   24
`define USC_BIT_ADDR_LO    16
`define USC_BIT_TXISEL_LO  14
`define USC_BIT_TXINV      13
`define USC_BIT_RXEN       12
`define USC_BIT_BRK        11
`define USC_BIT_TXEN       10
`define USC_BIT_TXBF       9
`define USC_BIT_SHIFT_EMPTY 8
`define USC_BIT_RXISEL_LO  6
`define USC_BIT_ADDR_CHAR  5
`define USC_BIT_RX_IDLE    4
`define USC_BIT_PAR_ERR    3
`define USC_BIT_FRM_ERR    2
`define USC_BIT_OVR_ERR    1
`define USC_BIT_RX_AVAIL   0

// Mode register fields
`define USC_BIT_ON         15
`define USC_BIT_IR_ENC     12

// Interrupt status bits
`define USC_IRQ_TX         0
`define USC_IRQ_BRKDONE    1
`define USC_IRQ_W          2

// Transmit-interrupt select codes
`define USC_TXI_SPACE      2'h0
`define USC_TXI_DONE       2'h1
`define USC_TXI_EMPTY      2'h2

// Sizes and timing
`define USC_FIFO_DEPTH     4
`define USC_BAUD_DIV       16'h0010
`define USC_BRK_ZEROS      4'hC
`define USC_DATA_BITS      4'h8
`define USC_IR_PULSE       16'h0004

`endif

// file: rtl/usc_pkg.sv
package usc_pkg;

	typedef struct packed {
		logic [7:0]  adr;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} usc_req_s;

	typedef enum logic [3:0] {
		USC_IDLE  = 4'h1,
		USC_START = 4'h2,
		USC_DATA  = 4'h4,
		USC_STOP  = 4'h8
	} usc_tx_state_e;

endpackage

// file: rtl/usc_status_control.sv
`timescale 1ns/1ps
`include "usc_defs.svh"

// Notes on behaviour
// RULE1: Bit 24 turns automatic address detection on or off.
// RULE2: Bits 23:16 hold the address character compared while detection is on.
// RULE3: Tx interrupt: 10 buffer empty, 01 all sent, 00 a slot free.
// RULE4: Without infrared, polarity bit set makes tx idle low, else high.
// RULE5: With infrared, polarity bit set makes encoded tx idle high, else low.
// RULE6: Receiver enable with module on claims the rx pin; otherwise port owns it.
// RULE7: Break request sends start, twelve zeros, stop on next transmission.
// RULE8: Hardware clears break request once the break is fully sent.
// RULE9: Tx enable with module on drives pin; clearing aborts and flushes buffer.
// RULE10: Read-only buffer-full flag: 1 full, 0 room for one more.
// RULE11: Bits 31:25 read zero and ignore writes.
// RULE12: After reset only shift-empty and rx-idle read one.
module usc_status_control
	import usc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	input  wire logic        rx_pin_i,
	input  wire logic [7:0]  rx_char_i,
	input  wire logic        rx_char_valid_i,
	output logic             rx_pin_owned_o,
	output logic             addr_match_o,
	output logic             tx_pin_o,
	output logic             tx_pin_owned_o,
	output logic             irq_o
);
	usc_req_s      req;
	usc_tx_state_e state;
	logic          addr_detect_enable;
	logic [7:0]    addr_char;
	logic [1:0]    tx_irq_select;
	logic          tx_idle_polarity;
	logic          rx_enable_bit;
	logic          break_request;
	logic          tx_enable_bit;
	logic [1:0]    rx_irq_select;
	logic          addr_char_enable;
	logic          module_on;
	logic          infrared_encode_enable;
	logic [`USC_IRQ_W-1:0] irq_stat;
	logic [`USC_IRQ_W-1:0] irq_mask;
	logic          tx_active;
	logic          tx_enabled;
	logic          sending_break;
	logic [15:0]   baud_cnt;
	logic          baud_tick;
	logic [3:0]    bit_cnt;
	logic [7:0]    shifter;
	logic          raw_line;
	logic          tx_level;
	logic          tx_buffer_full;
	logic          fifo_empty;
	logic [7:0]    fifo_data;
	logic          fifo_pop;
	logic          wr_sta;
	logic          wr_mode;
	logic          wr_data;
	logic          wr_istat;
	logic          wr_imask;
	logic          tx_shift_empty;
	logic          tx_irq_cond;
	logic          brk_done;
	logic [31:0]   sta_word;
	logic [31:0]   next_dat;

	assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};

	// Write strobes; a write lands on the acked edge only
	assign wr_sta   = cyc_i && stb_i && !ack_o && req.we && req.adr == `USC_ADDR_STA;
	assign wr_mode  = cyc_i && stb_i && !ack_o && req.we && req.adr == `USC_ADDR_MODE;
	assign wr_data  = cyc_i && stb_i && !ack_o && req.we && req.adr == `USC_ADDR_TXDATA;
	assign wr_istat = cyc_i && stb_i && !ack_o && req.we && req.adr == `USC_ADDR_IRQ_STAT;
	assign wr_imask = cyc_i && stb_i && !ack_o && req.we && req.adr == `USC_ADDR_IRQ_MASK;

	// One-cycle acknowledge, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i && stb_i && !ack_o;
	end

	// Control fields of the status/control word
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			addr_detect_enable <= 1'b0; // RULE12
			addr_char          <= 8'h00;
			tx_irq_select      <= 2'h0;
			tx_idle_polarity   <= 1'b0;
			rx_enable_bit      <= 1'b0;
			tx_enable_bit      <= 1'b0;
			rx_irq_select      <= 2'h0;
			addr_char_enable   <= 1'b0;
		end
		else if (wr_sta)
		begin
			if (req.sel[3])
				addr_detect_enable <= req.dat[`USC_BIT_ADDR_DET]; // RULE1 RULE11
			if (req.sel[2])
				addr_char <= req.dat[`USC_BIT_ADDR_LO +: 8]; // RULE2
			if (req.sel[1])
			begin
				tx_irq_select    <= req.dat[`USC_BIT_TXISEL_LO +: 2];
				tx_idle_polarity <= req.dat[`USC_BIT_TXINV];
				rx_enable_bit    <= req.dat[`USC_BIT_RXEN];
				tx_enable_bit    <= req.dat[`USC_BIT_TXEN];
			end
			if (req.sel[0])
			begin
				rx_irq_select    <= req.dat[`USC_BIT_RXISEL_LO +: 2];
				addr_char_enable <= req.dat[`USC_BIT_ADDR_CHAR];
			end
		end
	end

	// Break request; completion clears it, a new software set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			break_request <= 1'b0;
		else if (wr_sta && req.sel[1] && req.dat[`USC_BIT_BRK])
			break_request <= 1'b1; // RULE7
		else if (brk_done || !tx_enabled)
			break_request <= 1'b0; // RULE8
	end

	// Mode register: module on and infrared encoding
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			module_on              <= 1'b0;
			infrared_encode_enable <= 1'b0;
		end
		else if (wr_mode && req.sel[1])
		begin
			module_on              <= req.dat[`USC_BIT_ON];
			infrared_encode_enable <= req.dat[`USC_BIT_IR_ENC];
		end
	end

	assign tx_enabled     = module_on && tx_enable_bit;
	assign tx_pin_owned_o = tx_enabled; // RULE9
	assign rx_pin_owned_o = module_on && rx_enable_bit; // RULE6

	// Receive path only sees characters while it owns the pin
	usc_addr_match u_match (
		.enable_i     (addr_detect_enable),
		.addr_i       (addr_char),
		.char_i       (rx_char_i),
		.char_valid_i (rx_char_valid_i && rx_pin_owned_o), // RULE6
		.match_o      (addr_match_o)
	); // RULE1 RULE2

	// Buffer flushed whenever the transmitter is disabled
	usc_tx_fifo u_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (!tx_enabled), // RULE9
		.push_i  (wr_data && req.sel[0]),
		.data_i  (req.dat[7:0]),
		.pop_i   (fifo_pop),
		.data_o  (fifo_data),
		.empty_o (fifo_empty),
		.full_o  (tx_buffer_full)
	);

	// Bit-time divider
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state == USC_IDLE)
			baud_cnt <= 16'h0000;
		else if (baud_tick)
			baud_cnt <= 16'h0000;
		else
			baud_cnt <= baud_cnt + 16'h0001;
	end
	assign baud_tick = (baud_cnt == `USC_BAUD_DIV - 16'h0001);

	assign fifo_pop = tx_enabled && state == USC_IDLE && !break_request && !fifo_empty;

	// Transmit sequencer; a break uses twelve zero data bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !tx_enabled)
		begin
			state         <= USC_IDLE; // RULE9
			bit_cnt       <= 4'h0;
			shifter       <= 8'h00;
			sending_break <= 1'b0;
		end
		else
		begin
			case (state)
				USC_IDLE:
				begin
					if (break_request)
					begin
						sending_break <= 1'b1; // RULE7
						shifter       <= 8'h00;
						state         <= USC_START;
					end
					else if (!fifo_empty)
					begin
						sending_break <= 1'b0;
						shifter       <= fifo_data;
						state         <= USC_START;
					end
				end
				USC_START:
				begin
					if (baud_tick)
					begin
						bit_cnt <= 4'h0;
						state   <= USC_DATA;
					end
				end
				USC_DATA:
				begin
					if (baud_tick)
					begin
						shifter <= {1'b0, shifter[7:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == (sending_break ? `USC_BRK_ZEROS : `USC_DATA_BITS) - 4'h1)
							state <= USC_STOP; // RULE7
					end
				end
				USC_STOP:
				begin
					if (baud_tick)
						state <= USC_IDLE;
				end
				default:
					state <= USC_IDLE;
			endcase
		end
	end

	assign brk_done       = state == USC_STOP && baud_tick && sending_break; // RULE8
	assign tx_active      = state != USC_IDLE;
	assign tx_shift_empty = !tx_active; // RULE12

	// Line level before polarity and encoding
	always_comb
	begin
		case (state)
			USC_START: raw_line = 1'b0;
			USC_DATA:  raw_line = shifter[0];
			default:   raw_line = 1'b1;
		endcase
	end

	// Infrared output pulses zero bits at the level opposite idle; idle set by polarity
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_level <= 1'b1;
		else if (infrared_encode_enable)
			tx_level <= (!raw_line && baud_cnt < `USC_IR_PULSE) ^ tx_idle_polarity; // RULE5
		else
			tx_level <= raw_line ^ tx_idle_polarity; // RULE4
	end
	assign tx_pin_o = tx_level;

	// Transmit interrupt condition by select code
	always_comb
	begin
		case (tx_irq_select) // RULE3
			`USC_TXI_EMPTY: tx_irq_cond = fifo_empty;
			`USC_TXI_DONE:  tx_irq_cond = fifo_empty && !tx_active;
			`USC_TXI_SPACE: tx_irq_cond = !tx_buffer_full;
			default:        tx_irq_cond = 1'b0;
		endcase
	end

	// Sticky events, write-one-to-clear; a new event beats the clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~(wr_istat && req.sel[0] ? req.dat[`USC_IRQ_W-1:0] : '0))
				| {brk_done, tx_enabled && tx_irq_cond};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask <= '0;
		else if (wr_imask && req.sel[0])
			irq_mask <= req.dat[`USC_IRQ_W-1:0];
	end
	assign irq_o = |(irq_stat & irq_mask);

	// Status word; receive error flags are not fed here and read zero
	always_comb
	begin
		sta_word = 32'h0000_0000; // RULE11
		sta_word[`USC_BIT_ADDR_DET] = addr_detect_enable;
		sta_word[`USC_BIT_ADDR_LO +: 8] = addr_char;
		sta_word[`USC_BIT_TXISEL_LO +: 2] = tx_irq_select;
		sta_word[`USC_BIT_TXINV] = tx_idle_polarity;
		sta_word[`USC_BIT_RXEN] = rx_enable_bit;
		sta_word[`USC_BIT_BRK] = break_request;
		sta_word[`USC_BIT_TXEN] = tx_enable_bit;
		sta_word[`USC_BIT_TXBF] = tx_buffer_full; // RULE10
		sta_word[`USC_BIT_SHIFT_EMPTY] = tx_shift_empty;
		sta_word[`USC_BIT_RXISEL_LO +: 2] = rx_irq_select;
		sta_word[`USC_BIT_ADDR_CHAR] = addr_char_enable;
		sta_word[`USC_BIT_RX_IDLE] = !rx_pin_owned_o || rx_pin_i; // RULE12
	end

	// Read decode; unmapped addresses return zero
	always_comb
	begin
		if (req.adr == `USC_ADDR_STA)
			next_dat = sta_word;
		else if (req.adr == `USC_ADDR_MODE)
			next_dat = {16'h0000, module_on, 2'h0, infrared_encode_enable, 12'h000};
		else if (req.adr == `USC_ADDR_IRQ_STAT)
			next_dat = {30'h0, irq_stat};
		else if (req.adr == `USC_ADDR_IRQ_MASK)
			next_dat = {30'h0, irq_mask};
		else
			next_dat = 32'h0000_0000;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (cyc_i && stb_i && !ack_o && !req.we)
			dat_o <= next_dat;
	end

	chk_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |-> dat_o[31:25] == 7'h00) // RULE11
		else $error("upper status bits not zero");
	chk_break_len: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
		(state == USC_START && sending_break && baud_tick) |=> (state == USC_DATA)[*8])
		else $error("break too short");
	chk_break_bits: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
		$fell(state == USC_DATA) && sending_break |-> bit_cnt == `USC_BRK_ZEROS)
		else $error("break zero count wrong");
	chk_break_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		brk_done && !(wr_sta && req.sel[1] && req.dat[`USC_BIT_BRK]) |=> !break_request)
		else $error("break request not cleared");
	chk_txen_abort: assert property (@(posedge clk_i) disable iff (rst_i) !tx_enabled |=> state == USC_IDLE) // RULE9
		else $error("transmission not aborted");
	chk_full_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
		$rose(tx_buffer_full) |-> $past(wr_data))
		else $error("full without write");
	// Pin is registered, so it follows the polarity of one cycle earlier
	chk_idle_plain: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
		(!infrared_encode_enable && state == USC_IDLE)[*2] |-> tx_pin_o == !$past(tx_idle_polarity))
		else $error("plain idle level wrong");
	chk_idle_ir: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
		(infrared_encode_enable && state == USC_IDLE)[*2] |-> tx_pin_o == $past(tx_idle_polarity))
		else $error("infrared idle level wrong");
	chk_rx_owner: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		addr_match_o |-> rx_pin_owned_o && addr_detect_enable && rx_char_i == addr_char)
		else $error("match without ownership");
	chk_txirq_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		tx_enabled && tx_irq_select == `USC_TXI_EMPTY && fifo_empty |=> irq_stat[`USC_IRQ_TX])
		else $error("tx interrupt not raised");
	chk_reset_vals: assert property (@(posedge clk_i) $fell(rst_i) |-> tx_shift_empty && !break_request) // RULE12
		else $error("reset values wrong");
endmodule // usc_status_control

// file: rtl/usc_tx_fifo.sv
`timescale 1ns/1ps
`include "usc_defs.svh"

module usc_tx_fifo
	import usc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       flush_i,
	input  wire logic       push_i,
	input  wire logic [7:0] data_i,
	input  wire logic       pop_i,
	output logic [7:0]      data_o,
	output logic            empty_o,
	output logic            full_o
);
	logic [7:0] mem [`USC_FIFO_DEPTH];
	logic [1:0] wr_ptr;
	logic [1:0] rd_ptr;
	logic [2:0] count;

	// Pointers and occupancy; flush abandons all contents
	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			count  <= 3'h0;
		end
		else
		begin
			if (push_i && !full_o)
				wr_ptr <= wr_ptr + 2'h1;
			if (pop_i && !empty_o)
				rd_ptr <= rd_ptr + 2'h1;
			count <= count + {2'h0, push_i && !full_o} - {2'h0, pop_i && !empty_o};
		end
	end

	// Storage
	always_ff @(posedge clk_i)
	begin
		if (push_i && !full_o)
			mem[wr_ptr] <= data_i;
	end

	assign data_o  = mem[rd_ptr];
	assign empty_o = (count == 3'h0);
	assign full_o  = (count == 3'h4);
endmodule // usc_tx_fifo
